// File: rtl/bus_flags_pkg.sv
// Constants shared by the two-wire bus status-flag block
package bus_flags_pkg;
	localparam logic [11:0] STATUS_OFFSET = 12'h000;
	localparam logic [11:0] RX_HOLD_OFFSET = 12'h004;
	localparam logic [11:0] TX_HOLD_OFFSET = 12'h008;
	localparam logic [11:0] CTRL_OFFSET = 12'h00c;
	localparam int BEGIN_BIT = 3;
	localparam int DIR_BIT = 2;
	localparam int RX_FULL_BIT = 1;
	localparam int TX_FULL_BIT = 0;
	localparam int SLAVE_ADDR_LSB = 1;
	localparam logic [6:0] OWN_ADDR_RESET = 7'h2a;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
endpackage : bus_flags_pkg

// File: rtl/sync_bit.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
module sync_bit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : sync_bit

// File: rtl/toggle_sync.sv
// Event crossing by toggle, two flops and an edge detector
`timescale 1ns/1ns
module toggle_sync (
	input wire logic dst_clk,
	input wire logic dst_rst_n,
	input wire logic src_toggle,
	output logic pulse
);
	logic meta_r;
	logic sync_r;
	logic last_r;
	always_ff @(posedge dst_clk or negedge dst_rst_n)
	begin
		if (!dst_rst_n)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			meta_r <= src_toggle;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end
	assign pulse = sync_r ^ last_r;
endmodule : toggle_sync

// File: rtl/bus_status_flags.sv
// Two-wire bus target port: status flags, holding registers, APB slave
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
module bus_status_flags (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	// Link side runs on SCL itself; it samples SDA, the start toggle and the synchronised enable and tx-full flags.
	typedef enum {L_IDLE, L_ADDR, L_ACK, L_RX, L_TX, L_TXACK} link_state_t;

	logic apb_wr;
	logic apb_rd;
	logic [7:0] tx_hold_r;
	logic [6:0] own_addr_r;
	logic enable_r;
	logic begin_r;
	logic dir_r;
	logic rx_full_r;
	logic tx_full_r;
	logic rx_full_nxt;
	logic tx_full_nxt;
	logic rx_rd;
	logic tx_wr;
	logic [15:0] status_word;
	logic [7:0] rx_hold_r;

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Link domain (clocked by scl_in)
	link_state_t lstate_r;
	logic [7:0] shift_r;
	logic [2:0] bit_cnt_r;
	logic start_tgl_r;
	logic stop_tgl_r;
	logic addr_tgl_r;
	logic rx_tgl_r;
	logic txdone_tgl_r;
	logic link_dir_r;
	logic [7:0] rx_byte_r;
	logic sda_drive_r;
	logic link_rst_n;
	logic en_link;
	logic tx_full_link;

	// Start/stop: SDA edges while SCL high, seen in SDA edge domain
	logic start_seen_r;
	logic stop_seen_r;
	always_ff @(negedge sda_in or negedge presetn)
	begin
		if (!presetn)
			start_seen_r <= 1'b0;
		else if (scl_in)
			start_seen_r <= ~start_seen_r;
	end
	always_ff @(posedge sda_in or negedge presetn)
	begin
		if (!presetn)
			stop_seen_r <= 1'b0;
		else if (scl_in)
			stop_seen_r <= ~stop_seen_r;
	end

	// Start toggles seen by the SCL domain to restart framing
	logic start_ack_r;
	always_ff @(posedge scl_in or negedge presetn)
	begin
		if (!presetn)
			start_ack_r <= 1'b0;
		else
			start_ack_r <= start_seen_r;
	end
	assign link_rst_n = presetn;

	sync_bit u_en_link (
		.clk(scl_in),
		.rst_n(presetn),
		.d(enable_r),
		.q(en_link)
	);
	sync_bit u_tx_full_link (
		.clk(scl_in),
		.rst_n(presetn),
		.d(tx_full_r),
		.q(tx_full_link)
	);

	always_ff @(posedge scl_in or negedge link_rst_n)
	begin
		if (!link_rst_n)
		begin
			lstate_r <= L_IDLE;
			shift_r <= 8'h00;
			bit_cnt_r <= 3'h0;
			addr_tgl_r <= 1'b0;
			rx_tgl_r <= 1'b0;
			txdone_tgl_r <= 1'b0;
			link_dir_r <= 1'b0;
			rx_byte_r <= 8'h00;
		end
		else if (start_ack_r != start_seen_r)
		begin
			// First SCL rise after a start carries address bit 6, the MSB
			lstate_r <= L_ADDR;
			shift_r <= {7'h00, sda_in};
			bit_cnt_r <= 3'h1;
		end
		else
		begin
			unique case (lstate_r)
				L_IDLE:
					lstate_r <= L_IDLE;
				L_ADDR:
				begin
					shift_r <= {shift_r[6:0], sda_in};
					bit_cnt_r <= bit_cnt_r + 3'h1;
					if (bit_cnt_r == 3'h7)
					begin
						// Enable is judged late: SCL is still before a frame
						if (shift_r[6:0] == own_addr_r && en_link)
						begin
							link_dir_r <= sda_in;
							addr_tgl_r <= ~addr_tgl_r;
							lstate_r <= L_ACK;
						end
						else
							lstate_r <= L_IDLE;
					end
				end
				L_ACK:
				begin
					bit_cnt_r <= 3'h0;
					shift_r <= tx_hold_r;
					lstate_r <= link_dir_r ? L_TX : L_RX;
				end
				L_RX:
				begin
					shift_r <= {shift_r[6:0], sda_in};
					bit_cnt_r <= bit_cnt_r + 3'h1;
					if (bit_cnt_r == 3'h7)
					begin
						rx_byte_r <= {shift_r[6:0], sda_in};
						rx_tgl_r <= ~rx_tgl_r;
						lstate_r <= L_ACK;
					end
				end
				L_TX:
				begin
					bit_cnt_r <= bit_cnt_r + 3'h1;
					if (bit_cnt_r == 3'h7)
					begin
						txdone_tgl_r <= ~txdone_tgl_r;
						lstate_r <= L_TXACK;
					end
				end
				L_TXACK:
				begin
					bit_cnt_r <= 3'h0;
					shift_r <= tx_hold_r;
					// Master NACK (SDA high) ends the read
					lstate_r <= (sda_in || !tx_full_link) ? L_IDLE : L_TX;
				end
			endcase
		end
	end

	// Drive SDA on falling SCL so data is stable during the high phase
	always_ff @(negedge scl_in or negedge link_rst_n)
	begin
		if (!link_rst_n)
			sda_drive_r <= 1'b0;
		else if (lstate_r == L_ACK)
			sda_drive_r <= 1'b1;
		else if (lstate_r == L_TX)
			sda_drive_r <= !shift_r[7 - bit_cnt_r];
		else
			sda_drive_r <= 1'b0;
	end
	assign sda_out = 1'b0;
	assign sda_oe = sda_drive_r;

	// Crossings into pclk
	logic start_pulse;
	logic stop_pulse;
	logic addr_pulse;
	logic rx_pulse;
	logic txdone_pulse;
	toggle_sync u_start (
		.dst_clk(pclk),
		.dst_rst_n(presetn),
		.src_toggle(start_seen_r),
		.pulse(start_pulse)
	);
	toggle_sync u_stop (
		.dst_clk(pclk),
		.dst_rst_n(presetn),
		.src_toggle(stop_seen_r),
		.pulse(stop_pulse)
	);
	toggle_sync u_addr (
		.dst_clk(pclk),
		.dst_rst_n(presetn),
		.src_toggle(addr_tgl_r),
		.pulse(addr_pulse)
	);
	toggle_sync u_rx (
		.dst_clk(pclk),
		.dst_rst_n(presetn),
		.src_toggle(rx_tgl_r),
		.pulse(rx_pulse)
	);
	toggle_sync u_txd (
		.dst_clk(pclk),
		.dst_rst_n(presetn),
		.src_toggle(txdone_tgl_r),
		.pulse(txdone_pulse)
	);

	assign tx_wr = apb_wr && paddr == bus_flags_pkg::TX_HOLD_OFFSET;
	assign rx_rd = apb_rd && paddr == bus_flags_pkg::RX_HOLD_OFFSET;

	// Tx byte is quasi-static while the full flag is set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_hold_r <= 8'h00;
		else if (tx_wr)
			tx_hold_r <= pwdata[7:0];
	end

	// Address and enable are only safe to change while the bus is idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			own_addr_r <= bus_flags_pkg::OWN_ADDR_RESET;
			enable_r <= 1'b0;
		end
		else if (apb_wr && paddr == bus_flags_pkg::CTRL_OFFSET)
		begin
			enable_r <= pwdata[0];
			own_addr_r <= pwdata[bus_flags_pkg::SLAVE_ADDR_LSB +: 7];
		end
	end

	// Status flags: hardware-owned, APB writes to status are dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			begin_r <= 1'b0;
		else if (start_pulse)
			begin_r <= 1'b1;
		else if (stop_pulse)
			begin_r <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dir_r <= 1'b0;
		else if (addr_pulse)
			dir_r <= link_dir_r;
	end

	// rx_byte_r is stable for a whole byte time after its toggle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_hold_r <= 8'h00;
		else if (rx_pulse)
			rx_hold_r <= rx_byte_r;
	end

	// Set wins over a same-cycle clear
	always_comb
	begin
		rx_full_nxt = rx_full_r;
		if (rx_pulse)
			rx_full_nxt = 1'b1;
		else if (rx_rd)
			rx_full_nxt = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_full_r <= 1'b0;
		else
			rx_full_r <= rx_full_nxt;
	end

	// A new byte from software wins over the end of the old one
	always_comb
	begin
		tx_full_nxt = tx_full_r;
		if (tx_wr)
			tx_full_nxt = 1'b1;
		else if (txdone_pulse)
			tx_full_nxt = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_full_r <= 1'b0;
		else
			tx_full_r <= tx_full_nxt;
	end

	// Status word has no writable bits at all
	always_comb
	begin
		status_word = bus_flags_pkg::STATUS_RESET;
		status_word[bus_flags_pkg::BEGIN_BIT] = begin_r;
		status_word[bus_flags_pkg::DIR_BIT] = dir_r;
		status_word[bus_flags_pkg::RX_FULL_BIT] = rx_full_r;
		status_word[bus_flags_pkg::TX_FULL_BIT] = tx_full_r;
	end

	always_comb
	begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			bus_flags_pkg::STATUS_OFFSET:
				prdata[15:0] = status_word;
			bus_flags_pkg::RX_HOLD_OFFSET:
				prdata[7:0] = rx_hold_r;
			bus_flags_pkg::TX_HOLD_OFFSET:
				prdata[7:0] = tx_hold_r;
			bus_flags_pkg::CTRL_OFFSET:
				prdata[7:0] = {own_addr_r, enable_r};
			default:
				prdata = 32'h0000_0000;
		endcase
	end
endmodule : bus_status_flags

// File: verif/bus_flags_asserts.sv
// Port-level checks for the two-wire bus status-flag block
`timescale 1ns/1ns
module bus_flags_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sda_out,
	input wire logic sda_oe
);
	logic seen_r;
	wire acc = psel && penable;
	wire rd_st = acc && !pwrite && paddr == 12'h000;
	wire wr_st = acc && pwrite && paddr == 12'h000;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wr_tx;
		acc && pwrite && paddr == 12'h008;
	endsequence
	sequence rd_rx;
		acc && !pwrite && paddr == 12'h004;
	endsequence
	sequence rd_stat;
		rd_st;
	endsequence
	// Marks the first bus access after reset
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			seen_r <= 1'b0;
		else if (acc)
			seen_r <= 1'b1;
	a_ready_zero:
	assert property (acc |-> pready && !pslverr) else $error("bad answer");
	a_open_drain:
	assert property (sda_out == 1'b0) else $error("data driven high");
	a_tx_sets:
	assert property (wr_tx ##3 rd_stat |-> prdata[0])
		else $error("tx full not set");
	a_rx_clears:
	assert property (rd_rx ##3 rd_stat |-> !prdata[1])
		else $error("rx full not cleared");
	a_first_zero:
	assert property (!seen_r && rd_st |-> prdata[3:0] == 4'h0)
		else $error("flags not zero after reset");
	a_write_ignored:
	assert property ($past(rd_st, 6) && $past(wr_st, 3) && rd_st
		|-> prdata[3:0] == $past(prdata[3:0], 6))
		else $error("status write took effect");
	a_unmapped_zero:
	assert property (acc && !pwrite && paddr == 12'h010 |-> prdata == 0)
		else $error("unmapped read not zero");
	a_off_no_pull:
	assert property (!seen_r |-> !sda_oe) else $error("pull while off");
endmodule : bus_flags_asserts
bind bus_status_flags bus_flags_asserts u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sda_out(sda_out), .sda_oe(sda_oe));

// File: verif/bus_ctrl_model.sv
// Two-wire bus controller model driving clock and data
`timescale 1ns/1ns
module bus_ctrl_model (
	output logic scl,
	output logic sda_m,
	input wire logic sda_oe
);
	// Clock stands high between frames
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		sda_m = b;
		#8 scl = 1'b1;
		#8 r = b & ~sda_oe;
		#8 scl = 1'b0;
		#8;
	endtask : bit_io
	task automatic start();
		sda_m = 1'b1;
		#8 scl = 1'b1;
		#8 sda_m = 1'b0;
		#8 scl = 1'b0;
		#8;
	endtask : start
	task automatic stop();
		sda_m = 1'b0;
		#8 scl = 1'b1;
		#8 sda_m = 1'b1;
		#16;
	endtask : stop
	// Ninth bit always released: reads end with no acknowledge
	task automatic xfer(input logic [7:0] d, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : xfer
endmodule : bus_ctrl_model

// File: verif/i2c_status_flags_bench.sv
// Self-checking bench for the two-wire bus status flags
`timescale 1ns/1ns
module i2c_status_flags_bench;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, sda_out, sda_oe, scl, sda_m, ack;
	logic [7:0] d, r;
	logic [6:0] own;
	logic [3:0] m;
	integer fail_count, comparisons, seed;
	// Pull-up on the data line
	wire sda_in = sda_m & ~sda_oe;
	bus_status_flags uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
		.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));
	bus_ctrl_model host (.scl(scl), .sda_m(sda_m), .sda_oe(sda_oe));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		integer n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 64);
		if (pready !== 1'b1)
			fail_count++;
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic st();
		apb(1'b0, 12'h000, 32'h0);
		chk(q[3:0], m);
	endtask : st
	// Link events cross into the bus clock a few cycles late
	task automatic wt();
		repeat (5) @(posedge pclk);
	endtask : wt
	task automatic summarize();
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial
	begin
		#100000;
		fail_count++;
		summarize();
	end
	initial
	begin
		fail_count = 0;
		comparisons = 0;
		seed = 99;
		m = 4'h0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		own = bus_flags_pkg::OWN_ADDR_RESET;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		st();
		apb(1'b1, 12'h000, 32'hf);
		st();
		apb(1'b0, 12'h010, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, 12'h00c, {24'h0, own, 1'b1});
		d = $random(seed);
		apb(1'b1, 12'h008, {24'h0, d});
		m[0] = 1'b1;
		st();
		$display("register test done");
		host.start();
		wt();
		m[3] = 1'b1;
		st();
		host.xfer({own, 1'b1}, r, ack);
		wt();
		m[2] = 1'b1;
		st();
		host.xfer(8'hff, r, ack);
		chk(r, d);
		wt();
		m[0] = 1'b0;
		st();
		host.start();
		host.xfer({own, 1'b0}, r, ack);
		chk(ack, 1'b1);
		wt();
		m[2] = 1'b0;
		st();
		d = $random(seed);
		host.xfer(d, r, ack);
		wt();
		m[1] = 1'b1;
		st();
		apb(1'b0, 12'h004, 32'h0);
		chk(q[7:0], d);
		m[1] = 1'b0;
		st();
		host.stop();
		wt();
		m[3] = 1'b0;
		st();
		$display("link test done");
		summarize();
	end
endmodule : i2c_status_flags_bench
